/* rtl/spfs_pkg.sv */
/*
  shared constants of the 24-bit serial frame port: frame layout, opcodes,
  register map, status byte fields and timing counts.
  assumes a 25 MHz system clock on both ends.
*/
package spfs_pkg;
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h18;
  localparam logic [CNT_W-1:0] CNT_SAT = 5'h19;
  localparam logic [CNT_W-1:0] IDX_FIRST = 5'h17;
  localparam logic [CNT_W-1:0] IDX_DATA = 5'h10;
  localparam logic [CNT_W-1:0] CNT_CMD = 5'h08;

  typedef enum logic [1:0] {
    SPFS_OP_WRITE = 2'h0,
    SPFS_OP_READ = 2'h1,
    SPFS_OP_RDCLR = 2'h2,
    SPFS_OP_INFO = 2'h3
  } spfs_op_t;

  localparam logic [5:0] ADDR_ALL = 6'h3f;
  localparam logic [15:0] DATA_ALL = 16'hffff;
  localparam logic [5:0] INFO_ID_ADDR = 6'h00;

  localparam int unsigned NCTRL = 9;
  localparam logic [5:0] CTRL_ADDR [NCTRL] = '{6'h00, 6'h01, 6'h08, 6'h09, 6'h10, 6'h13, 6'h14, 6'h15, 6'h16};
  localparam logic [15:0] CTRL_RST [NCTRL] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                               16'h0000, 16'h0200, 16'h0200};
  localparam int unsigned NSTAT = 2;
  localparam logic [5:0] STAT_BASE = 6'h30;

  // status byte fields
  localparam int unsigned GSB_INV = 7;
  localparam int unsigned GSB_RST = 6;
  localparam int unsigned GSB_SERR = 5;
  localparam int unsigned GSB_TSD = 4;
  localparam int unsigned GSB_ITLOFF = 3;
  localparam int unsigned GSB_LOFF = 2;
  localparam int unsigned GSB_TCASE = 1;
  localparam int unsigned GSB_FS = 0;

  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned WD_TIMEOUT_NS = 100000000;
  localparam int unsigned CS_TIMEOUT_NS = 10000000;
  localparam int unsigned WD_CYCLES = WD_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned CS_TO_CYCLES = CS_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned HOST_HALF_CYCLES = 4;
  localparam int unsigned HOST_GAP_CYCLES = 8;
endpackage : spfs_pkg

/* rtl/spfs_if.sv */
/*
  the four-wire link between the frame port and its bus master.
  assumes a pull-up on the data-out line: released, it reads high.
*/
`timescale 1ns/10ps
interface spfs_if;
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;

  // released line modelled at its pull-up level, no tristate in the logic
  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport device (input cs_n, input sck, input sdi, output sdo, output sdo_oe);
  modport host (output cs_n, output sck, output sdi, input sdo_line);
endinterface : spfs_if

/* rtl/spfs_host_end.sv */
/*
  bus master end: sends one 24-bit frame per start pulse, mode 0, and
  returns the status byte and data word. assumes spfs_if on the link side.
*/
`timescale 1ns/10ps
module spfs_host_end
  import spfs_pkg::*;
#(
  parameter int unsigned HALF = HOST_HALF_CYCLES,
  parameter int unsigned GAP = HOST_GAP_CYCLES
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  spfs_if.host link,
  input wire logic start_in,
  input wire logic [7:0] cmd_in,
  input wire logic [15:0] wdata_in,
  output logic busy_out,
  output logic done_out,
  output logic [7:0] gsb_out,
  output logic [15:0] rdata_out
);
  // sdo is synchronised, so half a clock must outlast two flops
  if (HALF < 3 || HALF > 255 || GAP < 1 || GAP > 255) begin : g_chk
    $error("spfs_host_end: bad timing parameters");
  end

  typedef enum {SPFS_H_IDLE, SPFS_H_LOW, SPFS_H_HIGH, SPFS_H_TAIL, SPFS_H_GAP} spfs_hstate_t;
  spfs_hstate_t state_reg;
  logic cs_n_reg, sck_reg, sdi_reg;
  logic [FRAME_BITS-1:0] tx_reg, rx_reg;
  logic [CNT_W-1:0] bit_reg;
  logic [7:0] tmr_reg;
  logic sdo_s1_reg, sdo_s2_reg;
  logic [FRAME_BITS-1:0] frame_next;

  assign link.cs_n = cs_n_reg;
  assign link.sck = sck_reg;
  assign link.sdi = sdi_reg;

  always_ff @(posedge clk_in) begin
    sdo_s1_reg <= link.sdo_line;
    sdo_s2_reg <= sdo_s1_reg;
  end

  // last bit carries odd parity over the other 23
  always_comb begin
    frame_next = {cmd_in, wdata_in[15:1], 1'b0};
    frame_next[0] = ~(^frame_next[FRAME_BITS-1:1]);
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_reg <= SPFS_H_IDLE;
      cs_n_reg <= 1'b1;
      sck_reg <= 1'b0;
      sdi_reg <= 1'b0;
      tx_reg <= '0;
      rx_reg <= '0;
      bit_reg <= '0;
      tmr_reg <= 8'h00;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      gsb_out <= 8'h00;
      rdata_out <= 16'h0000;
    end else begin
      done_out <= 1'b0;
      if (tmr_reg != 8'h00) begin
        tmr_reg <= tmr_reg - 8'h01;
      end
      case (state_reg)
        SPFS_H_IDLE: begin
          if (start_in) begin
            // clock is already low when select falls
            cs_n_reg <= 1'b0;
            tx_reg <= {frame_next[FRAME_BITS-2:0], 1'b0};
            sdi_reg <= frame_next[FRAME_BITS-1];
            bit_reg <= '0;
            busy_out <= 1'b1;
            tmr_reg <= 8'(HALF - 1);
            state_reg <= SPFS_H_LOW;
          end
        end
        SPFS_H_LOW: begin
          if (tmr_reg == 8'h00) begin
            sck_reg <= 1'b1;
            rx_reg <= {rx_reg[FRAME_BITS-2:0], sdo_s2_reg};
            tmr_reg <= 8'(HALF - 1);
            state_reg <= SPFS_H_HIGH;
          end
        end
        SPFS_H_HIGH: begin
          if (tmr_reg == 8'h00) begin
            sck_reg <= 1'b0;
            tmr_reg <= 8'(HALF - 1);
            if (bit_reg == CNT_FULL - 5'h01) begin
              state_reg <= SPFS_H_TAIL;
            end else begin
              sdi_reg <= tx_reg[FRAME_BITS-1];
              tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0};
              bit_reg <= bit_reg + 5'h01;
              state_reg <= SPFS_H_LOW;
            end
          end
        end
        SPFS_H_TAIL: begin
          if (tmr_reg == 8'h00) begin
            cs_n_reg <= 1'b1;
            done_out <= 1'b1;
            gsb_out <= rx_reg[23:16];
            rdata_out <= rx_reg[15:0];
            tmr_reg <= 8'(GAP - 1);
            state_reg <= SPFS_H_GAP;
          end
        end
        SPFS_H_GAP: begin
          if (tmr_reg == 8'h00) begin
            busy_out <= 1'b0;
            state_reg <= SPFS_H_IDLE;
          end
        end
        default: begin
          state_reg <= SPFS_H_IDLE;
        end
      endcase
    end
  end
endmodule : spfs_host_end

/* rtl/spfs_device_end.sv */
/*
  device end of the 24-bit frame port: shift logic on the link clock,
  register file, status byte and timeouts on the system clock.
  assumes spfs_if on the link side and a master that keeps mode 0.
*/
`timescale 1ns/10ps
// Function
// - 24-bit frames, msb first both ways
// - sample input on each rising clock edge
// - first bit at select fall, then falling
// - deselected: output released to high-z
// - master starts clock low, mode zero
// - act only on exactly 24 bits
// - select idle too long: enter fail-safe
// - select low too long: release output
// - after timeout ignore frames until select rises
// - opcode, 6-bit address, then data high first
// - last frame bit is parity
// - status byte first, then data high first
// - opcode: write, read, read-clear, info
// - write stores data into addressed register
// - write returns the previous register value
// - unused address reads as zero
// - read-clear clears ones; all-ones address clears all
// - status msb is nor of rest, early
module spfs_device_end
  import spfs_pkg::*;
#(
  parameter int unsigned WD_LIMIT = WD_CYCLES,
  parameter int unsigned CS_TO_LIMIT = CS_TO_CYCLES,
  parameter logic [7:0] INFO_ID = 8'h5a // arbitrary value
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  spfs_if.device link,
  input wire logic tsd_in,
  input wire logic itloff_in,
  input wire logic loff_in,
  input wire logic tcase_in,
  input wire logic [NSTAT*16-1:0] status_set_in,
  output logic [NCTRL*16-1:0] ctrl_out,
  output logic fail_safe_out,
  output logic sw_reset_out
);
  if (WD_LIMIT < 2 || CS_TO_LIMIT < 2 || WD_LIMIT > 32'h7fffffff || CS_TO_LIMIT > 32'h7fffffff) begin : g_chk
    $error("spfs_device_end: bad timeout parameters");
  end

  function automatic int unsigned ctrl_slot(input logic [5:0] addr);
    int unsigned slot;
    slot = NCTRL;
    for (int unsigned i = 0; i < NCTRL; i++) begin
      if (CTRL_ADDR[i] == addr) begin
        slot = i;
      end
    end
    return slot;
  endfunction : ctrl_slot

  function automatic int unsigned stat_slot(input logic [5:0] addr);
    int unsigned slot;
    slot = NSTAT;
    for (int unsigned i = 0; i < NSTAT; i++) begin
      if (STAT_BASE + 6'(i) == addr) begin
        slot = i;
      end
    end
    return slot;
  endfunction : stat_slot

  // system side state
  logic [15:0] ctrl_reg [NCTRL];
  logic [15:0] stat_reg [NSTAT];
  logic [15:0] pend_reg [NSTAT];
  logic [7:0] gsb_frz_reg;
  logic rstb_reg, serr_reg, fs_reg, csto_reg, link_rst_reg;
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg, mark_seen_reg;
  logic [31:0] wd_cnt_reg, csto_cnt_reg;
  // link side state
  logic in_frame_reg, mark_reg;
  logic [CNT_W-1:0] cnt_reg, idx_reg;
  logic [FRAME_BITS-1:0] rx_reg;
  logic [15:0] dout_reg;

  logic [7:0] gsb_now;
  logic [15:0] rd_word;
  logic cs_rise, frame_ok;
  spfs_op_t op;
  logic [5:0] addr;
  logic [15:0] wdata;

  // link clock domain: capture side
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      in_frame_reg <= 1'b0;
    end else begin
      in_frame_reg <= 1'b1;
    end
  end

  // count survives select rising so the system side can judge it
  always_ff @(posedge link.sck or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      rx_reg <= '0;
      cnt_reg <= '0;
      mark_reg <= 1'b0;
    end else begin
      rx_reg <= {rx_reg[FRAME_BITS-2:0], link.sdi};
      if (!in_frame_reg) begin
        cnt_reg <= 5'h01;
        mark_reg <= ~mark_reg;
      end else if (cnt_reg != CNT_SAT) begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end

  // link clock domain: output side
  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      idx_reg <= IDX_FIRST;
      dout_reg <= 16'h0000;
    end else begin
      if (idx_reg != '0) begin
        idx_reg <= idx_reg - 5'h01;
      end
      if (idx_reg == IDX_DATA && cnt_reg == CNT_CMD) begin
        dout_reg <= rd_word;
      end
    end
  end

  // system registers are frozen while a frame runs, so this read is stable
  always_comb begin
    int unsigned cs, ss;
    cs = ctrl_slot(rx_reg[5:0]);
    ss = stat_slot(rx_reg[5:0]);
    rd_word = 16'h0000;
    if (spfs_op_t'(rx_reg[7:6]) == SPFS_OP_INFO) begin
      if (rx_reg[5:0] == INFO_ID_ADDR) begin
        rd_word = {INFO_ID, 8'h00};
      end
    end else if (cs < NCTRL) begin
      rd_word = ctrl_reg[cs];
    end else if (ss < NSTAT) begin
      rd_word = stat_reg[ss];
    end
  end

  assign link.sdo = (idx_reg >= IDX_DATA) ? gsb_frz_reg[idx_reg[2:0]] : dout_reg[idx_reg[3:0]];
  assign link.sdo_oe = ~link.cs_n & ~csto_reg;

  // system clock domain
  always_ff @(posedge clk_in) begin
    cs_s1_reg <= link.cs_n;
    cs_s2_reg <= cs_s1_reg;
    cs_s3_reg <= cs_s2_reg;
    link_rst_reg <= ~nrst_in;
  end

  assign cs_rise = cs_s2_reg & ~cs_s3_reg;
  assign op = spfs_op_t'(rx_reg[23:22]);
  assign addr = rx_reg[21:16];
  assign wdata = {rx_reg[15:1], 1'b0};
  assign frame_ok = cs_rise & ~csto_reg & (cnt_reg == CNT_FULL) & (mark_reg != mark_seen_reg);

  always_comb begin
    gsb_now = {1'b0, rstb_reg, serr_reg, tsd_in, itloff_in, loff_in, tcase_in, fs_reg};
    gsb_now[GSB_INV] = ~(|gsb_now[GSB_RST:GSB_FS]);
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      gsb_frz_reg <= 8'h00;
      mark_seen_reg <= 1'b0;
    end else begin
      // loaded until two clocks after select falls, then held while it stays low
      if (cs_s2_reg) begin
        gsb_frz_reg <= gsb_now;
      end
      if (cs_rise) begin
        mark_seen_reg <= mark_reg;
      end
    end
  end

  // select stuck low
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      csto_cnt_reg <= '0;
      csto_reg <= 1'b0;
    end else if (cs_s2_reg) begin
      csto_cnt_reg <= '0;
      csto_reg <= 1'b0;
    end else if (csto_cnt_reg == CS_TO_LIMIT - 1) begin
      csto_reg <= 1'b1;
    end else begin
      csto_cnt_reg <= csto_cnt_reg + 32'h1;
    end
  end

  // select stuck high in normal mode
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      wd_cnt_reg <= '0;
    end else if (!cs_s2_reg || fs_reg) begin
      wd_cnt_reg <= '0;
    end else if (wd_cnt_reg != WD_LIMIT - 1) begin
      wd_cnt_reg <= wd_cnt_reg + 32'h1;
    end
  end

  // flags: a set always beats a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rstb_reg <= 1'b1;
      serr_reg <= 1'b0;
      fs_reg <= 1'b1;
      sw_reset_out <= 1'b0;
    end else begin
      sw_reset_out <= 1'b0;
      if (frame_ok) begin
        rstb_reg <= 1'b0;
        serr_reg <= 1'b0;
        fs_reg <= 1'b0;
      end
      if (cs_rise && !csto_reg && !frame_ok) begin
        serr_reg <= 1'b1;
      end
      if (frame_ok && op == SPFS_OP_INFO && addr == ADDR_ALL) begin
        if (rx_reg[15:0] == DATA_ALL) begin
          serr_reg <= 1'b1;
        end else begin
          rstb_reg <= 1'b1;
          sw_reset_out <= 1'b1;
        end
      end
      if (cs_s2_reg && !fs_reg && wd_cnt_reg == WD_LIMIT - 1) begin
        fs_reg <= 1'b1;
      end
    end
  end

  assign fail_safe_out = fs_reg;

  generate
    for (genvar i = 0; i < NCTRL; i++) begin : g_ctrl
      always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
          ctrl_reg[i] <= CTRL_RST[i];
        end else if (frame_ok && op == SPFS_OP_INFO && addr == ADDR_ALL && rx_reg[15:0] != DATA_ALL) begin
          ctrl_reg[i] <= CTRL_RST[i];
        end else if (frame_ok && op == SPFS_OP_WRITE && ctrl_slot(addr) == i) begin
          ctrl_reg[i] <= wdata;
        end
      end
      assign ctrl_out[i*16 +: 16] = ctrl_reg[i];
    end

    // hardware sets wait in pend_reg while a frame runs
    for (genvar i = 0; i < NSTAT; i++) begin : g_stat
      logic [15:0] clr;
      always_comb begin
        clr = 16'h0000;
        if (frame_ok && op == SPFS_OP_RDCLR) begin
          if (addr == ADDR_ALL) begin
            clr = 16'hffff;
          end else if (stat_slot(addr) == i) begin
            // parity bit is not payload, so it never clears a flag
            clr = wdata;
          end
        end
      end
      always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
          stat_reg[i] <= 16'h0000;
          pend_reg[i] <= 16'h0000;
        end else if (cs_s2_reg) begin
          stat_reg[i] <= (stat_reg[i] & ~clr) | pend_reg[i] | status_set_in[i*16 +: 16];
          pend_reg[i] <= 16'h0000;
        end else begin
          pend_reg[i] <= pend_reg[i] | status_set_in[i*16 +: 16];
        end
      end
    end
  endgenerate
endmodule : spfs_device_end

/* verification/spfs_link_sva.sv */
/*
  link checker: select, clock and data timing of the frame link.
  assumes the link is sampled on the host system clock.
*/
`timescale 1ns/10ps
module spfs_link_sva (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic sck_q_reg;
  logic [5:0] rise_cnt_reg;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sck_q_reg <= 1'b0;
    end else begin
      sck_q_reg <= sck;
    end
  end
  // rises per frame, cleared while deselected
  always_ff @(posedge clk_in) begin
    if (!nrst_in || cs_n) begin
      rise_cnt_reg <= 6'h00;
    end else if (sck && !sck_q_reg) begin
      rise_cnt_reg <= rise_cnt_reg + 6'h01;
    end
  end
  sequence s_high_half;
    sck [*4] ##1 !sck;
  endsequence
  property p_oe_off;
    cs_n |-> !sdo_oe;
  endproperty
  property p_start_low;
    $fell(cs_n) |-> !sck [*4];
  endproperty
  property p_sck_idle;
    cs_n |-> !sck;
  endproperty
  property p_sck_half;
    $rose(sck) |-> s_high_half;
  endproperty
  property p_sdi_hold;
    sck |-> $stable(sdi);
  endproperty
  // first bit skipped: it settles with the select fall
  property p_sdo_hold;
    !cs_n && rise_cnt_reg != 6'h00 && !$fell(sck) |-> $stable(sdo);
  endproperty
  property p_oe_on;
    $fell(cs_n) |-> sdo_oe [*8];
  endproperty
  property p_count24;
    $rose(cs_n) |-> rise_cnt_reg == 6'h18;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("data out driven while deselected");
  a_start_low: assert property (p_start_low)
    else $error("clock not low at frame start");
  a_sck_idle: assert property (p_sck_idle)
    else $error("clock moves while deselected");
  a_sck_half: assert property (p_sck_half)
    else $error("clock high phase wrong");
  a_sdi_hold: assert property (p_sdi_hold)
    else $error("data in moved while clock high");
  a_sdo_hold: assert property (p_sdo_hold)
    else $error("data out moved off a falling edge");
  a_oe_on: assert property (p_oe_on)
    else $error("data out not driven after select fall");
  a_count24: assert property (p_count24)
    else $error("frame not 24 clocks");
endmodule : spfs_link_sva

/* verification/spi_frame_slave_interface_tb.sv */
/*
  bench: host end against device end, plus a bench-driven second link
  for broken frames. assumes a 25 MHz clk_in.
*/
`timescale 1ns/10ps
module spi_frame_slave_interface_tb;
  import spfs_pkg::*;
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] wd;
    logic [15:0] rd;
    logic chk;
  } spfs_row_t;
  localparam int unsigned CS_TO = 400;
  localparam int unsigned WD = 1000;
  localparam logic [7:0] ID = 8'h3c; // arbitrary value
  localparam spfs_row_t ROWS [12] = '{
    '{8'h15, 16'h1234, 16'h0200, 1'b1}, '{8'h55, 16'h0000, 16'h1234, 1'b1},
    '{8'h00, 16'habcd, 16'h0000, 1'b1}, '{8'h40, 16'h0000, 16'habcc, 1'b1},
    '{8'h42, 16'h0000, 16'h0000, 1'b1}, '{8'hc0, 16'h0000, {ID, 8'h00}, 1'b1},
    '{8'hb0, 16'h00f0, 16'h00ff, 1'b1}, '{8'h70, 16'h0000, 16'h000f, 1'b1},
    '{8'hbf, 16'h0000, 16'h0000, 1'b0}, '{8'h71, 16'h0000, 16'h0000, 1'b1},
    '{8'hff, 16'h0000, 16'h0000, 1'b0}, '{8'h55, 16'h0000, 16'h0200, 1'b1}};
  logic clk_in, nrst_in, start_in, busy_out, done_out, fail_safe_out, sw_reset_out;
  logic tsd_in, itloff_in, loff_in, tcase_in, fs_b, oe;
  logic [7:0] cmd_in, gsb_out, g;
  logic [15:0] wdata_in, rdata_out, r;
  logic [23:0] rx;
  logic [NSTAT*16-1:0] status_set_in;
  logic [NCTRL*16-1:0] ctrl_out, ctrl_b;
  int n_errors = 0;
  int samples_checked = 0;
  int sw_pulses = 0;
  spfs_if lnk ();
  spfs_if lnk2 ();
  spfs_host_end u_spfs_host_end (.clk_in(clk_in), .nrst_in(nrst_in), .link(lnk.host), .start_in(start_in),
    .cmd_in(cmd_in), .wdata_in(wdata_in), .busy_out(busy_out), .done_out(done_out), .gsb_out(gsb_out),
    .rdata_out(rdata_out));
  spfs_device_end #(.WD_LIMIT(WD), .CS_TO_LIMIT(CS_TO), .INFO_ID(ID)) u_spfs_device_end (.clk_in(clk_in),
    .nrst_in(nrst_in), .link(lnk.device), .tsd_in(tsd_in), .itloff_in(itloff_in), .loff_in(loff_in),
    .tcase_in(tcase_in), .status_set_in(status_set_in), .ctrl_out(ctrl_out), .fail_safe_out(fail_safe_out),
    .sw_reset_out(sw_reset_out));
  // second device faces the bench directly, for frames the host end never makes
  spfs_device_end #(.WD_LIMIT(WD), .CS_TO_LIMIT(CS_TO), .INFO_ID(ID)) u_spfs_device_end_b (.clk_in(clk_in),
    .nrst_in(nrst_in), .link(lnk2.device), .tsd_in(tsd_in), .itloff_in(itloff_in), .loff_in(loff_in),
    .tcase_in(tcase_in), .status_set_in(status_set_in), .ctrl_out(ctrl_b), .fail_safe_out(fs_b),
    .sw_reset_out());
  spfs_link_sva u_spfs_link_sva (.clk_in(clk_in), .nrst_in(nrst_in), .cs_n(lnk.cs_n), .sck(lnk.sck),
    .sdi(lnk.sdi), .sdo(lnk.sdo), .sdo_oe(lnk.sdo_oe));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (sw_reset_out === 1'b1) begin
      sw_pulses++;
    end
  end
  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_word(what, {15'h0000, exp}, {15'h0000, got});
  endtask : chk_bit
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  task automatic wait_for(input bit idle);
    int k;
    k = 0;
    while ((idle ? busy_out : !done_out) !== 1'b0) begin
      @(negedge clk_in);
      k++;
      if (k > 600) begin
        n_errors++;
        $display("[FAIL] handshake expected 1 seen 0");
        end_of_test();
      end
    end
  endtask : wait_for
  task automatic host_frame(input logic [7:0] cmd, input logic [15:0] wd);
    @(posedge clk_in);
    start_in <= 1'b1;
    cmd_in <= cmd;
    wdata_in <= wd;
    @(posedge clk_in);
    start_in <= 1'b0;
    wait_for(1'b0);
    g = gsb_out;
    r = rdata_out;
    wait_for(1'b1);
  endtask : host_frame
  // bench as master, 125 ns link clock off the system phase; pre holds select low first
  task automatic raw_frame(input int nbits, input logic [23:0] word, input int pre);
    @(posedge clk_in);
    lnk2.cs_n <= 1'b0;
    repeat (pre + 1) @(posedge clk_in);
    #13;
    oe = lnk2.sdo_oe;
    rx = 24'h000000;
    for (int i = 0; i < nbits; i++) begin
      lnk2.sdi <= word[23-i];
      #62.5;
      rx = {rx[22:0], lnk2.sdo_line};
      lnk2.sck <= 1'b1;
      #62.5;
      lnk2.sck <= 1'b0;
    end
    #62.5;
    @(posedge clk_in);
    lnk2.cs_n <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask : raw_frame
  initial begin
    nrst_in = 1'b0;
    {start_in, tsd_in, itloff_in, loff_in, tcase_in} = 5'h00;
    {lnk2.cs_n, lnk2.sck, lnk2.sdi} = 3'h4;
    cmd_in = 8'h00;
    wdata_in = 16'h0000;
    status_set_in = '0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    status_set_in <= {16'h0f00, 16'h00ff};
    @(posedge clk_in);
    status_set_in <= '0;
    foreach (ROWS[i]) begin
      host_frame(ROWS[i].cmd, ROWS[i].wd);
      if (ROWS[i].chk) begin
        chk_word("rdata", ROWS[i].rd, r);
      end
      chk_bit("status msb", ~|g[6:0], g[7]);
    end
    chk_bit("sw reset pulse", 1'b1, sw_pulses == 1);
    @(posedge clk_in);
    {tsd_in, itloff_in, loff_in, tcase_in} <= 4'hf;
    repeat (8) @(posedge clk_in);
    host_frame(8'h55, 16'h0000);
    chk_word("status", 16'h001e, {8'h00, g});
    @(posedge clk_in);
    {tsd_in, itloff_in, loff_in, tcase_in} <= 4'h0;
    chk_bit("fail safe", 1'b0, fail_safe_out);
    repeat (WD + 50) @(posedge clk_in);
    chk_bit("fail safe", 1'b1, fail_safe_out);
    host_frame(8'h15, 16'h0f00);
    chk_word("rdata", 16'h0200, r);
    chk_bit("status fs", 1'b1, g[0]);
    chk_word("ctrl", 16'h0f00, ctrl_out[7*16 +: 16]);
    raw_frame(24, {8'h14, 16'h0055}, 0);
    chk_bit("oe", 1'b1, oe);
    chk_word("rdata", 16'h0000, rx[15:0]);
    chk_word("ctrl", 16'h0054, ctrl_b[6*16 +: 16]);
    chk_bit("fail safe b", 1'b0, fs_b);
    raw_frame(23, {8'h14, 16'h00aa}, 0);
    raw_frame(24, {8'h54, 16'h0000}, 0);
    chk_word("rdata", 16'h0054, rx[15:0]);
    chk_bit("status serr", 1'b1, rx[21]);
    raw_frame(24, {8'h14, 16'h00f0}, 450);
    chk_bit("oe", 1'b0, oe);
    chk_word("rdata", 16'hffff, rx[15:0]);
    raw_frame(24, {8'h54, 16'h0000}, 0);
    chk_bit("oe", 1'b1, oe);
    chk_word("rdata", 16'h0054, rx[15:0]);
    nrst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk_bit("fail safe", 1'b1, fail_safe_out);
    host_frame(8'h55, 16'h0000);
    chk_word("rdata", 16'h0200, r);
    chk_word("status", 16'h0041, {8'h00, g});
    end_of_test();
  end
endmodule : spi_frame_slave_interface_tb
